// *** rtl/fir_cfg.svh ***
`ifndef FIR_CFG_SVH
`define FIR_CFG_SVH

// Register map on the plain register port
`define FIR_ADDR_CTRL    4'h0
`define FIR_ADDR_STAT    4'h4

// Control word fields
`define FIR_CTRL_RM      1:0
`define FIR_CTRL_PS      3:2
`define FIR_CTRL_MASK    32'h0000000f

// Status word bits; 4:0 sticky, write one to clear
`define FIR_ST_INEX      0
`define FIR_ST_OVFL      1
`define FIR_ST_UNFL      2
`define FIR_ST_SNAN      3
`define FIR_ST_UNSUP     4
`define FIR_ST_NAN       8
`define FIR_ST_INF       9
`define FIR_ST_ZERO      10

// Exponent biases and maxima, 16-bit two's complement domain
`define FIR_SGL_BIAS     16'h007f
`define FIR_DBL_BIAS     16'h03ff
`define FIR_EXT_BIAS     16'h3fff
`define FIR_SGL_EMAX     16'h00ff
`define FIR_DBL_EMAX     16'h07ff
`define FIR_EXT_EMAX     16'h7fff
`define FIR_ZERO_EXP     16'h8000

// Mantissa precisions in bits and the 67-bit intermediate width
`define FIR_PRECISION_SELECT_SGL     7'h18
`define FIR_PRECISION_SELECT_DBL     7'h35
`define FIR_PRECISION_SELECT_EXT     7'h40
`define FIR_IMANT_W      7'h43

// Quiet bit of a 64-bit mantissa and the generated NAN mantissa
`define FIR_QUIET_MASK   64'h4000000000000000
`define FIR_GEN_NAN      64'hffffffffffffffff

// Packed decimal special pattern
`define FIR_PK_SPECIAL   15'h7fff

`endif

// *** rtl/fir_pkg.sv ***
package fir_pkg;

  typedef enum logic [1:0] {
    FIR_FMT_SGL = 2'b00,
    FIR_FMT_DBL = 2'b01,
    FIR_FMT_EXT = 2'b10,
    FIR_FMT_PKD = 2'b11
  } fir_fmt_t;

  typedef enum logic [1:0] {
    FIR_OP_MOVE  = 2'b00,
    FIR_OP_ADD   = 2'b01,
    FIR_OP_SUB   = 2'b10,
    FIR_OP_STORE = 2'b11
  } fir_op_t;

  typedef enum logic [1:0] {
    FIR_RM_NEAREST = 2'b00,
    FIR_RM_ZERO    = 2'b01,
    FIR_RM_MINUS   = 2'b10,
    FIR_RM_PLUS    = 2'b11
  } fir_rmode_t;

  // Unpacked operand, exponent unbiased two's complement
  typedef struct packed {
    logic        sign;
    logic [15:0] exp;
    logic [63:0] mant;
    logic        zero;
    logic        inf;
    logic        nan;
    logic        snan;
    logic        unsup;
  } fir_unp_t;

  function automatic logic [6:0] fir_lzc(input logic [67:0] x);
    logic [6:0] c;
    logic       hit;
    c   = 7'h00;
    hit = 1'b0;
    for (int i = 67; i >= 0; i--)
    begin
      if (!hit)
      begin
        if (x[i])
          hit = 1'b1;
        else
          c = c + 7'h01;
      end
    end
    return c;
  endfunction

endpackage

// *** rtl/fir_opnd_if.sv ***
`timescale 1ns/1ns
interface fir_opnd_if;
  import fir_pkg::*;
  logic [95:0] raw;
  fir_fmt_t    fmt;
  logic        norm;
  fir_unp_t    unp;
  modport unit (input raw, input fmt, input norm, output unp);
  modport user (output raw, output fmt, output norm, input unp);
endinterface

// *** rtl/fir_unpack.sv ***
`timescale 1ns/1ns
`include "fir_cfg.svh"
module fir_unpack
(
  // Operand in memory image, unpacked result out
  fir_opnd_if.unit port
);
  import fir_pkg::*;

  fir_unp_t   u;
  logic [6:0] lz;

  always_comb
  begin
    u  = '0;
    lz = 7'h00;
    unique case (port.fmt)
      FIR_FMT_SGL:
      begin
        u.sign = port.raw[31];
        u.mant = {1'b1, port.raw[22:0], 40'h0};
        if (port.raw[30:23] == 8'hff)
        begin
          u.nan  = |port.raw[22:0];
          u.inf  = ~u.nan;
          u.snan = u.nan & ~port.raw[22];
        end
        else if (port.raw[30:23] == 8'h00)
        begin
          u.mant[63] = 1'b0;
          u.exp      = 16'h0001 - `FIR_SGL_BIAS;
        end
        else
          u.exp = {8'h00, port.raw[30:23]} - `FIR_SGL_BIAS;
      end
      FIR_FMT_DBL:
      begin
        u.sign = port.raw[63];
        u.mant = {1'b1, port.raw[51:0], 11'h0};
        if (port.raw[62:52] == 11'h7ff)
        begin
          u.nan  = |port.raw[51:0];
          u.inf  = ~u.nan;
          u.snan = u.nan & ~port.raw[51];
        end
        else if (port.raw[62:52] == 11'h000)
        begin
          u.mant[63] = 1'b0;
          u.exp      = 16'h0001 - `FIR_DBL_BIAS;
        end
        else
          u.exp = {5'h00, port.raw[62:52]} - `FIR_DBL_BIAS;
      end
      FIR_FMT_EXT:
      begin
        u.sign = port.raw[95];
        u.mant = port.raw[63:0];
        if ({1'b0, port.raw[94:80]} == `FIR_EXT_EMAX)
        begin
          u.nan  = |port.raw[62:0];
          u.inf  = ~u.nan;
          u.snan = u.nan & ~port.raw[62];
        end
        else
          u.exp = {1'b0, port.raw[94:80]} - `FIR_EXT_BIAS;
      end
      FIR_FMT_PKD:
      begin
        u.sign = port.raw[95];
        u.mant = {1'b1, port.raw[62:0]};
        if (port.raw[94:80] == `FIR_PK_SPECIAL)
        begin
          u.nan  = |port.raw[63:0];
          u.inf  = ~u.nan;
          u.snan = u.nan & ~port.raw[63];
        end
        else
          u.unsup = 1'b1;
      end
    endcase
    // Unnormalized zero becomes a true zero first
    if (!u.nan && !u.inf && (u.unsup || u.mant == 64'h0))
    begin
      u.zero = 1'b1;
      u.mant = 64'h0;
      u.exp  = `FIR_ZERO_EXP;
    end
    else if (port.norm && !u.nan && !u.inf)
    begin
      lz     = fir_lzc({u.mant, 4'h0});
      u.mant = u.mant << lz;
      u.exp  = u.exp - {9'h000, lz};
    end
    port.unp = u;
  end

endmodule

// *** rtl/fir_top.sv ***
`timescale 1ns/1ns
`include "fir_cfg.svh"
module fir_top
#(
  parameter int ADDR_W = 4
)
(
  // Clock and reset
  input  logic                 sys_clk,
  input  logic                 rst,
  // Register port
  input  logic [ADDR_W-1:0]    reg_addr,
  input  logic [31:0]          reg_wdata,
  input  logic                 reg_wr,
  input  logic                 reg_rd,
  output logic [31:0]          reg_rdata,
  // Operation request
  input  logic                 op_valid,
  input  fir_pkg::fir_op_t     op_code,
  input  fir_pkg::fir_fmt_t    op_fmt,
  input  logic [95:0]          op_src_a,
  input  logic [95:0]          op_src_b,
  // Result
  output logic                 res_valid,
  output logic [95:0]          res_data,
  output logic                 res_nan,
  output logic                 res_snan,
  output logic                 res_inexact
);
  import fir_pkg::*;

  if (ADDR_W < 3 || ADDR_W > 16)
  begin : g_chk
    $error("fir_top: ADDR_W must be 3..16");
  end

  function automatic logic [95:0] pack(input fir_fmt_t f, input logic sg,
                                       input logic [15:0] be, input logic [63:0] m);
    logic [95:0] d;
    d = 96'h0;
    case (f)
      FIR_FMT_SGL: d = {64'h0, sg, be[7:0], m[62:40]};
      FIR_FMT_DBL: d = {32'h0, sg, be[10:0], m[62:11]};
      FIR_FMT_EXT: d = {sg, be[14:0], 16'h0, m};
      FIR_FMT_PKD:
      begin
        if (be == `FIR_EXT_EMAX)
          d = {sg, `FIR_PK_SPECIAL, 16'h0, m};
        else
          d = {sg, 95'h0};
      end
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0] fp_control_word;
  logic [31:0] fp_status_word;
  logic [4:0]  st_set;
  logic [2:0]  last_cls;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      fp_control_word <= 32'h0;
    else if (reg_wr && reg_addr == ADDR_W'(`FIR_ADDR_CTRL))
      fp_control_word <= reg_wdata & `FIR_CTRL_MASK;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      fp_status_word <= 32'h0;
    else
    begin
      fp_status_word[4:0] <= (fp_status_word[4:0]
        & ~((reg_wr && reg_addr == ADDR_W'(`FIR_ADDR_STAT)) ? reg_wdata[4:0] : 5'h00))
        | st_set;
      fp_status_word[10:8] <= last_cls;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      if (reg_addr == ADDR_W'(`FIR_ADDR_CTRL))
        reg_rdata <= fp_control_word;
      else if (reg_addr == ADDR_W'(`FIR_ADDR_STAT))
        reg_rdata <= fp_status_word;
      else
        reg_rdata <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stage 0: capture request and choose rounding precision
  logic        s0_valid;
  fir_op_t     s0_op;
  fir_fmt_t    s0_fmt;
  fir_rmode_t  s0_rm;
  logic [6:0]  s0_precision_select;
  logic [95:0] s0_a;
  logic [95:0] s0_b;
  logic [6:0]  next_precision_select;

  always_comb
  begin
    next_precision_select = `FIR_PRECISION_SELECT_EXT;
    if (op_code == FIR_OP_STORE)
    begin
      if (op_fmt == FIR_FMT_SGL)
        next_precision_select = `FIR_PRECISION_SELECT_SGL;
      else if (op_fmt == FIR_FMT_DBL)
        next_precision_select = `FIR_PRECISION_SELECT_DBL;
    end
    else if (op_code != FIR_OP_MOVE)
    begin
      if (fp_control_word[`FIR_CTRL_PS] == 2'b01)
        next_precision_select = `FIR_PRECISION_SELECT_SGL;
      else if (fp_control_word[`FIR_CTRL_PS] == 2'b10)
        next_precision_select = `FIR_PRECISION_SELECT_DBL;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s0_valid <= 1'b0;
      s0_op    <= FIR_OP_MOVE;
      s0_fmt   <= FIR_FMT_EXT;
      s0_rm    <= FIR_RM_NEAREST;
      s0_precision_select  <= `FIR_PRECISION_SELECT_EXT;
      s0_a     <= 96'h0;
      s0_b     <= 96'h0;
    end
    else
    begin
      s0_valid <= op_valid;
      s0_op    <= op_code;
      s0_fmt   <= op_fmt;
      s0_rm    <= fir_rmode_t'(fp_control_word[`FIR_CTRL_RM]);
      s0_precision_select  <= next_precision_select;
      s0_a     <= op_src_a;
      s0_b     <= op_src_b;
    end
  end

  // Widen both operands; a register source is always extended
  fir_opnd_if ua ();
  fir_opnd_if ub ();
  assign ua.raw  = s0_a;
  assign ua.fmt  = (s0_op == FIR_OP_STORE) ? FIR_FMT_EXT : s0_fmt;
  assign ua.norm = (s0_op != FIR_OP_MOVE);
  assign ub.raw  = s0_b;
  assign ub.fmt  = FIR_FMT_EXT;
  assign ub.norm = 1'b1;

  fir_unpack u_unp_a (.port(ua.unit));
  fir_unpack u_unp_b (.port(ub.unit));

  ////////////////////////////////////////////////////////////////////////////////
  // Stage 1: exact intermediate result
  fir_unp_t    a;
  fir_unp_t    b;
  fir_unp_t    big;
  fir_unp_t    sml;
  fir_unp_t    pick;
  logic [15:0] d;
  logic [66:0] al;
  logic [67:0] sum;
  logic [67:0] next_mant;
  logic        s1_valid;
  fir_op_t     s1_op;
  fir_fmt_t    s1_fmt;
  fir_rmode_t  s1_rm;
  logic [6:0]  s1_precision_select;
  fir_unp_t    s1;
  logic [67:0] s1_mant;

  always_comb
  begin
    a         = ua.unp;
    b         = ub.unp;
    b.sign    = ub.unp.sign ^ (s0_op == FIR_OP_SUB);
    big       = a;
    sml       = b;
    d         = 16'h0;
    al        = 67'h0;
    sum       = 68'h0;
    pick      = a;
    next_mant = {1'b0, a.mant, 3'h0};
    if (s0_op == FIR_OP_ADD || s0_op == FIR_OP_SUB)
    begin
      if (!a.nan && b.nan)
        pick = b;
      else if (!a.nan && a.inf && b.inf && a.sign != b.sign)
      begin
        pick.sign = 1'b0;
        pick.mant = `FIR_GEN_NAN;
        pick.nan  = 1'b1;
        pick.inf  = 1'b0;
      end
      else if (!a.nan && !a.inf && (b.inf || a.zero))
        pick = b;
      if (a.zero && b.zero)
        pick.sign = (s0_rm == FIR_RM_MINUS) ? (a.sign | b.sign) : (a.sign & b.sign);
      pick.snan  = a.snan | b.snan;
      pick.unsup = a.unsup | b.unsup;
      next_mant  = {1'b0, pick.mant, 3'h0};
      if (!a.nan && !b.nan && !a.inf && !b.inf && !a.zero && !b.zero)
      begin
        if ($signed(b.exp) > $signed(a.exp) || (a.exp == b.exp && b.mant > a.mant))
        begin
          big = b;
          sml = a;
        end
        d  = big.exp - sml.exp;
        al = {sml.mant, 3'h0} >> d;
        al[0] = al[0] | (|({sml.mant, 3'h0} & ((67'h1 << d) - 67'h1)));
        if (a.sign != b.sign)
          sum = {1'b0, big.mant, 3'h0} - {1'b0, al};
        else
          sum = {1'b0, big.mant, 3'h0} + {1'b0, al};
        pick      = big;
        pick.snan = 1'b0;
        next_mant = sum;
        if (sum == 68'h0)
        begin
          pick.zero = 1'b1;
          pick.sign = (s0_rm == FIR_RM_MINUS);
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_valid <= 1'b0;
      s1_op    <= FIR_OP_MOVE;
      s1_fmt   <= FIR_FMT_EXT;
      s1_rm    <= FIR_RM_NEAREST;
      s1_precision_select  <= `FIR_PRECISION_SELECT_EXT;
      s1       <= '0;
      s1_mant  <= 68'h0;
    end
    else
    begin
      s1_valid <= s0_valid;
      s1_op    <= s0_op;
      s1_fmt   <= s0_fmt;
      s1_rm    <= s0_rm;
      s1_precision_select  <= s0_precision_select;
      s1       <= pick;
      s1_mant  <= next_mant;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Stage 2: normalize, round, narrow the exponent, pack
  fir_fmt_t     dfmt;
  logic [15:0]  bias;
  logic [15:0]  emax;
  logic [66:0]  n;
  logic [15:0]  ne;
  logic [6:0]   lz;
  logic [6:0]   lsb;
  logic         g;
  logic         r;
  logic         s;
  logic         inc;
  logic [64:0]  kept;
  logic [63:0]  rm64;
  logic [17:0]  be;
  logic [95:0]  next_data;
  logic         next_inex;
  logic         next_ovfl;
  logic         next_unfl;
  logic         arith;

  always_comb
  begin
    arith = (s1_op != FIR_OP_MOVE);
    dfmt  = (s1_op == FIR_OP_STORE) ? s1_fmt : FIR_FMT_EXT;
    case (dfmt)
      FIR_FMT_SGL: begin bias = `FIR_SGL_BIAS; emax = `FIR_SGL_EMAX; end
      FIR_FMT_DBL: begin bias = `FIR_DBL_BIAS; emax = `FIR_DBL_EMAX; end
      default:     begin bias = `FIR_EXT_BIAS; emax = `FIR_EXT_EMAX; end
    endcase
    lz = 7'h00;
    if (arith && s1_mant[67])
    begin
      n  = {s1_mant[67:2], |s1_mant[1:0]};
      ne = s1.exp + 16'h0001;
    end
    else if (arith)
    begin
      lz = fir_lzc({s1_mant[66:0], 1'b1});
      n  = s1_mant[66:0] << lz;
      ne = s1.exp - {9'h000, lz};
    end
    else
    begin
      n  = s1_mant[66:0];
      ne = s1.exp;
    end
    lsb  = `FIR_IMANT_W - s1_precision_select;
    g    = n[lsb - 7'h01];
    r    = n[lsb - 7'h02];
    s    = |(n & ((67'h1 << (lsb - 7'h02)) - 67'h1));
    kept = {1'b0, 64'(n >> lsb)};
    unique case (s1_rm)
      FIR_RM_NEAREST: inc = g & (r | s | kept[0]);
      FIR_RM_ZERO:    inc = 1'b0;
      FIR_RM_MINUS:   inc = s1.sign & (g | r | s);
      FIR_RM_PLUS:    inc = ~s1.sign & (g | r | s);
    endcase
    kept = kept + {64'h0, inc};
    if (kept[s1_precision_select])
    begin
      kept = kept >> 1;
      ne   = ne + 16'h0001;
    end
    rm64      = kept[63:0] << (`FIR_PRECISION_SELECT_EXT - s1_precision_select);
    be        = {ne[15], ne[15], ne} + {2'b00, bias};
    next_inex = 1'b0;
    next_ovfl = 1'b0;
    next_unfl = 1'b0;
    if (s1.nan)
      next_data = pack(dfmt, s1.sign, emax,
                       s1.mant | (arith ? `FIR_QUIET_MASK : 64'h0));
    else if (s1.inf)
      next_data = pack(dfmt, s1.sign, emax, 64'h0);
    else if (s1.zero)
      next_data = pack(dfmt, s1.sign, 16'h0000, 64'h0);
    else if ($signed(be) >= $signed({2'b00, emax}))
    begin
      next_ovfl = 1'b1;
      next_data = pack(dfmt, s1.sign, emax, 64'h0);
    end
    else if (arith && $signed(be) <= 18'sh0)
    begin
      next_unfl = 1'b1;
      next_data = pack(dfmt, s1.sign, 16'h0000, 64'h0);
    end
    else
    begin
      next_inex = g | r | s;
      next_data = pack(dfmt, s1.sign, be[15:0], rm64);
    end
  end

  assign st_set = s1_valid ? {s1.unsup, s1.snan, next_unfl, next_ovfl, next_inex} : 5'h00;

  // Fixed pipeline depth, independent of precision
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      res_valid   <= 1'b0;
      res_data    <= 96'h0;
      res_nan     <= 1'b0;
      res_snan    <= 1'b0;
      res_inexact <= 1'b0;
      last_cls    <= 3'h0;
    end
    else
    begin
      res_valid <= s1_valid;
      if (s1_valid)
      begin
        res_data    <= next_data;
        res_nan     <= s1.nan;
        res_snan    <= s1.snan;
        res_inexact <= next_inex;
        last_cls    <= {s1.zero | next_unfl, s1.inf | next_ovfl, s1.nan};
      end
    end
  end

endmodule

// *** sim/fir_top_props.sv ***
`timescale 1ns/1ns
module fir_top_props
  import fir_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  // Clock and reset
  input logic              sys_clk,
  input logic              rst,
  // Register port
  input logic [ADDR_W-1:0] reg_addr,
  input logic [31:0]       reg_wdata,
  input logic              reg_wr,
  input logic              reg_rd,
  input logic [31:0]       reg_rdata,
  // Operation request
  input logic              op_valid,
  input fir_op_t           op_code,
  input fir_fmt_t          op_fmt,
  input logic [95:0]       op_src_a,
  input logic [95:0]       op_src_b,
  // Result
  input logic              res_valid,
  input logic [95:0]       res_data,
  input logic              res_nan,
  input logic              res_snan,
  input logic              res_inexact
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic [1:0] ps;
  logic       add_x;
  logic       a_nan;
  logic       a_frac;

  // Shadow of precision_select, updated by the same writes the block sees
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      ps <= 2'h0;
    else if (reg_wr && reg_addr == '0)
      ps <= reg_wdata[3:2];
  end

  assign add_x = op_valid && op_code == FIR_OP_ADD && op_fmt == FIR_FMT_EXT;
  // Integer bit plays no part in telling a NAN from an infinity
  assign a_frac = op_src_a[62:0] != 63'h0;
  assign a_nan  = op_src_a[94:80] == 15'h7fff && a_frac;

  ////////////////////////////////////////////////////////////////////////////
  AST_RES_LAT: assert property (op_valid |-> ##3 res_valid)
    else $error("result not three cycles after request");
  AST_RES_CAUSE: assert property (res_valid |-> $past(op_valid, 3))
    else $error("result without request");
  AST_HOLD: assert property (!res_valid |-> $stable(res_data))
    else $error("result changed between results");
  AST_NAN_DET: assert property (add_x && a_nan |-> ##3 res_nan)
    else $error("nan operand not seen as nan");
  AST_SNAN: assert property (add_x && a_nan && !op_src_a[62] |-> ##3 res_snan)
    else $error("signaling nan not flagged");
  AST_QUIET: assert property (add_x && a_nan |-> ##3 res_data[62])
    else $error("nan result not quiet");
  AST_DNRM_MOVE: assert property (op_valid && op_code == FIR_OP_MOVE && op_fmt == FIR_FMT_EXT
    && op_src_a[94:80] == 15'h0 && op_src_a[63:62] == 2'b00
    |-> ##3 res_data[94:80] == 15'h0 && !res_data[63])
    else $error("moved denormal was normalized");
  AST_PRECISION_SELECT_SGL: assert property (add_x && ps == 2'b01
    |-> ##3 res_nan || res_data[39:0] == 40'h0)
    else $error("bits below single precision not zero");
  AST_PRECISION_SELECT_DBL: assert property (add_x && ps == 2'b10
    |-> ##3 res_nan || res_data[10:0] == 11'h0)
    else $error("bits below double precision not zero");
  AST_PK_SPEC: assert property (op_valid && op_code == FIR_OP_STORE && op_fmt == FIR_FMT_PKD
    && op_src_a[94:80] == 15'h7fff |-> ##3 res_data[94:80] == 15'h7fff
    && ((res_data[63:0] != 64'h0) == $past(a_frac, 3)))
    else $error("packed special pattern wrong");

  CV_ADD: cover property (add_x ##3 res_inexact);
  CV_PKD: cover property (op_valid && op_fmt == FIR_FMT_PKD);
  CV_SNAN: cover property (res_valid && res_snan);
endmodule

bind fir_top fir_top_props #(.ADDR_W(ADDR_W)) u_props (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .op_valid(op_valid), .op_code(op_code), .op_fmt(op_fmt),
  .op_src_a(op_src_a), .op_src_b(op_src_b), .res_valid(res_valid), .res_data(res_data),
  .res_nan(res_nan), .res_snan(res_snan), .res_inexact(res_inexact));

// *** sim/fir_iu_model.sv ***
`timescale 1ns/1ns
module fir_iu_model
  import fir_pkg::*;
(
  // Clock
  input  logic        sys_clk,
  // Operation request toward the datapath
  output logic        op_valid,
  output fir_op_t     op_code,
  output fir_fmt_t    op_fmt,
  output logic [95:0] op_src_a,
  output logic [95:0] op_src_b
);
  initial
  begin
    op_valid = 1'b0;
    op_code  = FIR_OP_MOVE;
    op_fmt   = FIR_FMT_EXT;
    op_src_a = 96'h0;
    op_src_b = 96'h0;
  end

  // Operands scrambled once the request drops, so stale data cannot pass
  task automatic issue(input fir_op_t c, input fir_fmt_t f, input logic [95:0] a, b);
    @(posedge sys_clk);
    op_valid <= 1'b1;
    op_code  <= c;
    op_fmt   <= f;
    op_src_a <= a;
    op_src_b <= b;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    op_src_a <= ~a;
    op_src_b <= ~b;
  endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ns
`include "fir_cfg.svh"
module tb;
  import fir_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        op_valid;
  fir_op_t     op_code;
  fir_fmt_t    op_fmt;
  logic [95:0] op_src_a;
  logic [95:0] op_src_b;
  logic        res_valid;
  logic [95:0] res_data;
  logic        res_nan;
  logic        res_snan;
  logic        res_inexact;
  int          err_total = 0;
  int          n_compared = 0;

  always #20 sys_clk = ~sys_clk;

  fir_iu_model iu (.sys_clk(sys_clk), .op_valid(op_valid), .op_code(op_code),
    .op_fmt(op_fmt), .op_src_a(op_src_a), .op_src_b(op_src_b));
  fir_top dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
    .op_code(op_code), .op_fmt(op_fmt), .op_src_a(op_src_a), .op_src_b(op_src_b),
    .res_valid(res_valid), .res_data(res_data), .res_nan(res_nan), .res_snan(res_snan),
    .res_inexact(res_inexact));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [95:0] x(input logic s, input logic [14:0] e, input logic [63:0] m);
    return {s, e, 16'h0000, m};
  endfunction

  localparam logic [95:0] ONE = {1'b0, 15'h3fff, 16'h0, 64'h8000000000000000};

  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk({64'h0, reg_rdata & m}, {64'h0, e});
  endtask

  // Result stands one cycle, so it is looked at just after the edge that raises it
  task automatic t_op(input fir_op_t c, input fir_fmt_t f, input logic [95:0] a, b, e,
                      input logic [2:0] ne, input logic [95:0] m = '1);
    iu.issue(c, f, a, b);
    repeat (2) @(posedge sys_clk);
    #1;
    chk({95'h0, res_valid}, 96'h1);
    chk(res_data & m, e & m);
    chk({93'h0, res_nan, res_snan, res_inexact}, {93'h0, ne});
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_total++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`FIR_ADDR_CTRL, '1, 32'h0);
    rd(`FIR_ADDR_STAT, '1, 32'h0);
    rd(4'h8, '1, 32'h0);
    $display("test reset done");
    t_op(FIR_OP_ADD, FIR_FMT_EXT, ONE, ONE, x(0, 15'h4000, 64'h8000000000000000), 3'b000);
    t_op(FIR_OP_SUB, FIR_FMT_EXT, x(0, 15'h4000, 64'h8000000000000000), ONE, ONE, 3'b000);
    rd(`FIR_ADDR_STAT, 32'h1f, 32'h0);
    t_op(FIR_OP_ADD, FIR_FMT_EXT, ONE, x(0, 15'h3fbf, 64'h8000000000000000), ONE, 3'b001);
    t_op(FIR_OP_ADD, FIR_FMT_EXT, x(0, 15'h3fff, 64'h8000000000000001),
         x(0, 15'h3fbf, 64'h8000000000000000), x(0, 15'h3fff, 64'h8000000000000002), 3'b001);
    t_op(FIR_OP_ADD, FIR_FMT_EXT, ONE, x(0, 15'h3fbf, 64'hc000000000000000),
         x(0, 15'h3fff, 64'h8000000000000001), 3'b001);
    t_op(FIR_OP_ADD, FIR_FMT_EXT, ONE, x(0, 15'h3fbf, 64'h8000000000000001),
         x(0, 15'h3fff, 64'h8000000000000001), 3'b001);
    rd(`FIR_ADDR_STAT, 32'h1f, 32'h1);
    wr(`FIR_ADDR_STAT, 32'h1f);
    rd(`FIR_ADDR_STAT, 32'h1f, 32'h0);
    $display("test rounding done");
    wr(`FIR_ADDR_CTRL, 32'h4);
    rd(`FIR_ADDR_CTRL, '1, 32'h4);
    t_op(FIR_OP_ADD, FIR_FMT_EXT, ONE, x(0, 15'h3fe7, 64'h8000000000000000), ONE, 3'b001);
    t_op(FIR_OP_ADD, FIR_FMT_EXT, ONE, x(0, 15'h3fe7, 64'hc000000000000000),
         x(0, 15'h3fff, 64'h8000010000000000), 3'b001);
    t_op(FIR_OP_STORE, FIR_FMT_EXT, x(0, 15'h3fff, 64'h8000000000000001), 96'h0,
         x(0, 15'h3fff, 64'h8000000000000001), 3'b000);
    t_op(FIR_OP_STORE, FIR_FMT_DBL, x(0, 15'h3fff, 64'h8000000000000010), 96'h0,
         96'h3ff0000000000000, 3'b001, {32'h0, 64'hffffffffffffffff});
    t_op(FIR_OP_STORE, FIR_FMT_SGL, x(0, 15'h3fff, 64'hc000000000000000), 96'h0,
         96'h3fc00000, 3'b000, 96'hffffffff);
    wr(`FIR_ADDR_CTRL, 32'h8);
    t_op(FIR_OP_ADD, FIR_FMT_EXT, ONE, x(0, 15'h3fca, 64'hc000000000000000),
         x(0, 15'h3fff, 64'h8000000000000800), 3'b001);
    $display("test precision done");
    wr(`FIR_ADDR_CTRL, 32'h0);
    t_op(FIR_OP_MOVE, FIR_FMT_SGL, 96'h3fc00000, 96'h0, x(0, 15'h3fff, 64'hc000000000000000), 3'b000);
    t_op(FIR_OP_MOVE, FIR_FMT_DBL, 96'h4000000000000000, 96'h0,
         x(0, 15'h4000, 64'h8000000000000000), 3'b000);
    t_op(FIR_OP_MOVE, FIR_FMT_EXT, x(0, 15'h0, 64'h1234), 96'h0, x(0, 15'h0, 64'h1234), 3'b000);
    t_op(FIR_OP_MOVE, FIR_FMT_DBL, 96'h1, 96'h0, x(0, 15'h3c01, 64'h800), 3'b000);
    t_op(FIR_OP_ADD, FIR_FMT_DBL, 96'h1, 96'h0, x(0, 15'h3bcd, 64'h8000000000000000), 3'b000);
    t_op(FIR_OP_ADD, FIR_FMT_EXT, x(0, 15'h3fff, 64'h4000000000000000), 96'h0,
         x(0, 15'h3ffe, 64'h8000000000000000), 3'b000);
    t_op(FIR_OP_ADD, FIR_FMT_EXT, x(0, 15'h3fff, 64'h0), ONE, ONE, 3'b000);
    $display("test operands done");
    t_op(FIR_OP_ADD, FIR_FMT_EXT, x(1, 15'h7fff, 64'h4000000000000001), ONE,
         x(1, 15'h7fff, 64'h4000000000000001), 3'b100);
    t_op(FIR_OP_ADD, FIR_FMT_EXT, x(0, 15'h7fff, 64'h1), ONE,
         x(0, 15'h7fff, 64'h4000000000000001), 3'b110);
    t_op(FIR_OP_SUB, FIR_FMT_EXT, x(0, 15'h7fff, 64'h0), x(0, 15'h7fff, 64'h0),
         x(0, 15'h7fff, 64'hffffffffffffffff), 3'b100);
    t_op(FIR_OP_ADD, FIR_FMT_EXT, x(0, 15'h7fff, 64'h0), ONE, x(0, 15'h7fff, 64'h0), 3'b000);
    rd(`FIR_ADDR_STAT, 32'h8, 32'h8);
    t_op(FIR_OP_ADD, FIR_FMT_EXT, x(0, 15'h7ffe, 64'h8000000000000000),
         x(0, 15'h7ffe, 64'h8000000000000000), x(0, 15'h7fff, 64'h0), 3'b000);
    rd(`FIR_ADDR_STAT, 32'h2, 32'h2);
    $display("test nan done");
    t_op(FIR_OP_STORE, FIR_FMT_PKD, x(0, 15'h7fff, 64'h0), 96'h0, {16'h7fff, 80'h0},
         3'b000, {16'hffff, 16'h0, 64'hffffffffffffffff});
    t_op(FIR_OP_STORE, FIR_FMT_PKD, x(0, 15'h7fff, 64'hc000000000000000), 96'h0,
         {16'h7fff, 80'h0}, 3'b100, {16'hffff, 80'h0});
    t_op(FIR_OP_MOVE, FIR_FMT_PKD, {16'h7fff, 80'h0}, 96'h0, x(0, 15'h7fff, 64'h0),
         3'b000, {16'hffff, 16'h0, 64'h7fffffffffffffff});
    $display("test packed done");
    close_out();
  end
endmodule
